// >>> design/pfc_pkg.sv
package pfc_pkg;

   // ==========================================================
   // Bus and array geometry
   // ==========================================================
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int CTRL_W = 16;
   localparam int WORD_W = 24;
   localparam int FADDR_W = 16;
   localparam int ROW_WORDS = 32;
   localparam int ROW_BYTES = 96;
   localparam int IDX_W = 5;
   localparam int CNT_W = 4;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFF_KEY = 8'h04;
   localparam logic [APB_AW-1:0] OFF_STAT = 8'h08;
   localparam logic [APB_AW-1:0] OFF_CLR = 8'h0c;
   localparam logic [APB_AW-1:0] OFF_IEN = 8'h10;
   localparam logic [APB_AW-1:0] OFF_TADDR = 8'h14;
   localparam logic [APB_AW-1:0] OFF_TDATA = 8'h18;

   // ==========================================================
   // Control register fields
   // ==========================================================
   localparam int CTRL_WR_BIT = 15;
   localparam int CTRL_OPERATION_ENABLE_BIT_BIT = 14;
   localparam int CTRL_ERR_BIT = 13;
   localparam int CTRL_SKIP_AUTO_ERASE_BIT_BIT = 12;
   localparam int CTRL_ERASE_BIT = 6;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_OP_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   localparam logic [CTRL_OP_W-1:0] CMD_ERASE8 = 6'h1a;
   localparam logic [CTRL_OP_W-1:0] CMD_ERASE4 = 6'h19;
   localparam logic [CTRL_OP_W-1:0] CMD_ERASE2 = 6'h18;
   localparam logic [CTRL_OP_W-1:0] CMD_ERASE_EE = 6'h10;
   localparam logic [2:0] CMD_WRITE_TAG = 3'h1;
   localparam logic [CNT_W-1:0] WORDS_8 = 4'h8;
   localparam logic [CNT_W-1:0] WORDS_4 = 4'h4;
   localparam logic [CNT_W-1:0] WORDS_2 = 4'h2;
   localparam logic [CNT_W-1:0] WORDS_1 = 4'h1;

   // ==========================================================
   // Protection and interrupts
   // ==========================================================
   localparam logic [2:0] BSS_OFF = 3'h7;
   localparam logic [FADDR_W-1:0] BOOT_SEG_END = 16'h0400;
   localparam int EV_W = 3;
   localparam int EV_DONE = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_REFUSED = 2;
   localparam int SER_RX_W = 8;
   localparam int SER_CNT_W = 5;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LATCH = 2'b01,
      ST_ERASE = 2'b10,
      ST_PROG = 2'b11
   } pfc_state_t;

   typedef enum logic [1:0] {
      KEY_NONE = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b10
   } pfc_key_t;

   typedef enum logic [1:0] {
      FOP_ERASE = 2'b00,
      FOP_PROG = 2'b01,
      FOP_ERASE_EE = 2'b10
   } pfc_fop_t;

   typedef struct packed {
      pfc_fop_t kind;
      logic [CNT_W-1:0] words;
      logic [FADDR_W-1:0] addr;
      logic [WORD_W-1:0] data;
   } pfc_flash_req_t;

endpackage

// >>> design/pfc_latch_mem.sv
`timescale 1ns/1ns
module pfc_latch_mem import pfc_pkg::*; (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic we_i,
   input wire logic [IDX_W-1:0] waddr_i,
   input wire logic [WORD_W-1:0] wdata_i,
   input wire logic [IDX_W-1:0] raddr_i,
   output logic [WORD_W-1:0] rdata_o
);

   typedef struct packed {
      logic [ROW_WORDS-1:0][WORD_W-1:0] mem;
      logic [WORD_W-1:0] rdata;
   } pfc_mem_state_t;

   pfc_mem_state_t s_q;
   pfc_mem_state_t s_d;

   // ==========================================================
   // Row holding latches
   // ==========================================================
   always_comb begin
      s_d = s_q;
      // Any order, any number of rewrites; last write wins
      if (we_i) begin
         s_d.mem[waddr_i] = wdata_i;
      end
      s_d.rdata = s_q.mem[raddr_i];
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata_o = s_q.rdata;

endmodule // pfc_latch_mem

// >>> design/pfc_flash_ctrl.sv
// Behaviour
// - Key writes 55h then AAh back to back before start is accepted.
// - Unlock key register is write-only and always reads zero.
// - Processor stays stalled while an operation is in progress.
// - Start bit 15 launches the operation; hardware clears it at the end.
// - Error flag bit 13 set on reset abort; zero after normal completion.
// - Code protection blocks program memory access from the programming port.
// - Code protection leaves normal fetch and execution untouched.
// - Write-lock bit at zero blocks internal write and erase of its segment.
// - Serial port uses programmer-driven clock and a two-way data line.
// - Rows of 32 words, 96 bytes; blocks aligned from memory start.
// - Table writes land in row holding latches, not the array.
// - Latches load in any order; a later write replaces the earlier.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
module pfc_flash_ctrl import pfc_pkg::*; (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [APB_DW-1:0] pwdata_i,
   output logic [APB_DW-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   output logic cpu_stall_o,
   input wire logic abort_reset_i,
   output logic flash_req_o,
   output pfc_flash_req_t flash_cmd_o,
   input wire logic flash_done_i,
   input wire logic [2:0] boot_segment_protect_field_i,
   input wire logic general_segment_protect_bit_i,
   input wire logic boot_segment_write_lock_i,
   input wire logic general_segment_write_lock_i,
   input wire logic programming_clock_line_i,
   input wire logic programming_data_line_i,
   output logic programming_data_line_o,
   output logic programming_data_line_oe_o,
   input wire logic ext_tx_load_i,
   input wire logic [WORD_W-1:0] ext_tx_word_i,
   output logic [SER_RX_W-1:0] ext_rx_byte_o,
   output logic ext_rx_valid_o
);

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      pfc_key_t key;
      pfc_state_t st;
      logic then_prog;
      logic [FADDR_W-1:0] taddr;
      logic [EV_W-1:0] stat;
      logic [EV_W-1:0] ien;
      logic [APB_DW-1:0] prdata;
      pfc_flash_req_t fq;
      logic sck_s1;
      logic sck_s2;
      logic sck_s3;
      logic sda_s1;
      logic sda_s2;
      logic [SER_RX_W-1:0] rx_sh;
      logic [SER_CNT_W-1:0] rx_cnt;
      logic [SER_RX_W-1:0] rx_byte;
      logic rx_valid;
      logic [WORD_W-1:0] tx_sh;
      logic [SER_CNT_W-1:0] tx_cnt;
      logic tx_bit;
   } pfc_core_state_t;

   pfc_core_state_t s_q;
   pfc_core_state_t s_d;

   logic [WORD_W-1:0] latch_rdata;
   logic latch_we;
   logic apb_setup;
   logic apb_acc;
   logic mapped;
   logic ext_allow;
   logic [EV_W-1:0] ev;
   logic [EV_W-1:0] clr;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [FADDR_W-1:0] align_addr(input logic [FADDR_W-1:0] a,
                                                     input logic [CNT_W-1:0] words);
      align_addr = a & ~(FADDR_W'(words) - FADDR_W'(1));
   endfunction

   function automatic logic seg_locked(input logic [FADDR_W-1:0] a, input logic boot_wl,
                                       input logic gen_wl);
      seg_locked = (a < BOOT_SEG_END) ? ~boot_wl : ~gen_wl;
   endfunction

   // ==========================================================
   // Row holding latches
   // ==========================================================
   assign latch_we = apb_acc & pwrite_i & (paddr_i == OFF_TDATA) & ~s_q.ctrl[CTRL_WR_BIT];

   pfc_latch_mem u_latch (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .we_i(latch_we),
      .waddr_i(s_q.taddr[IDX_W-1:0]),
      .wdata_i(pwdata_i[WORD_W-1:0]),
      .raddr_i(s_q.taddr[IDX_W-1:0]),
      .rdata_o(latch_rdata)
   );

   // ==========================================================
   // APB slave decode
   // ==========================================================
   assign apb_setup = psel_i & ~penable_i;
   assign apb_acc = psel_i & penable_i;
   assign mapped = (paddr_i == OFF_CTRL) | (paddr_i == OFF_KEY) | (paddr_i == OFF_STAT) |
                   (paddr_i == OFF_CLR) | (paddr_i == OFF_IEN) | (paddr_i == OFF_TADDR) |
                   (paddr_i == OFF_TDATA);
   // Zero wait states: read data is captured in the setup cycle
   assign pready_o = 1'b1;
   assign pslverr_o = apb_acc & ~mapped;
   assign clr = (apb_acc & pwrite_i & (paddr_i == OFF_CLR)) ? pwdata_i[EV_W-1:0] : '0;

   // Protection only gates the serial port; fetch has no path through here
   assign ext_allow = (boot_segment_protect_field_i == BSS_OFF) & general_segment_protect_bit_i;

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      logic erase_sel;
      logic [CTRL_OP_W-1:0] op;
      logic [CNT_W-1:0] words;
      logic legal;
      logic is_ee;
      logic sck_rise;
      logic sck_fall;
      s_d = s_q;
      ev = '0;
      erase_sel = s_q.ctrl[CTRL_ERASE_BIT];
      op = s_q.ctrl[CTRL_OP_LSB +: CTRL_OP_W];
      words = WORDS_1;
      legal = 1'b0;
      is_ee = 1'b0;
      sck_rise = s_q.sck_s2 & ~s_q.sck_s3;
      sck_fall = ~s_q.sck_s2 & s_q.sck_s3;

      // Register reads, captured during setup
      if (apb_setup) begin
         unique case (paddr_i)
            OFF_CTRL: s_d.prdata = APB_DW'(s_q.ctrl);
            OFF_STAT: s_d.prdata = APB_DW'(s_q.stat);
            OFF_IEN: s_d.prdata = APB_DW'(s_q.ien);
            OFF_TADDR: s_d.prdata = APB_DW'(s_q.taddr);
            default: s_d.prdata = '0;
         endcase
      end

      // Unlock tracker: any other access between the key writes breaks it
      if (apb_acc) begin
         s_d.key = KEY_NONE;
         if (pwrite_i && paddr_i == OFF_KEY) begin
            if (s_q.key == KEY_HALF && pwdata_i[7:0] == KEY_SECOND) begin
               s_d.key = KEY_OPEN;
            end else if (pwdata_i[7:0] == KEY_FIRST) begin
               s_d.key = KEY_HALF;
            end
         end
      end

      // Register writes; control is frozen while an operation runs
      if (apb_acc && pwrite_i) begin
         if (paddr_i == OFF_CTRL && !s_q.ctrl[CTRL_WR_BIT]) begin
            s_d.ctrl[CTRL_OPERATION_ENABLE_BIT_BIT] = pwdata_i[CTRL_OPERATION_ENABLE_BIT_BIT];
            s_d.ctrl[CTRL_ERR_BIT] = pwdata_i[CTRL_ERR_BIT];
            s_d.ctrl[CTRL_SKIP_AUTO_ERASE_BIT_BIT] = pwdata_i[CTRL_SKIP_AUTO_ERASE_BIT_BIT];
            s_d.ctrl[CTRL_ERASE_BIT] = pwdata_i[CTRL_ERASE_BIT];
            s_d.ctrl[CTRL_OP_LSB +: CTRL_OP_W] = pwdata_i[CTRL_OP_LSB +: CTRL_OP_W];
            // Start only with enable set and the key sequence just completed
            if (pwdata_i[CTRL_WR_BIT] && pwdata_i[CTRL_OPERATION_ENABLE_BIT_BIT] && s_q.key == KEY_OPEN) begin
               s_d.ctrl[CTRL_WR_BIT] = 1'b1;
               s_d.st = ST_LATCH;
            end
         end
         if (paddr_i == OFF_IEN) begin
            s_d.ien = pwdata_i[EV_W-1:0];
         end
         if (paddr_i == OFF_TADDR && !s_q.ctrl[CTRL_WR_BIT]) begin
            s_d.taddr = pwdata_i[FADDR_W-1:0];
         end
      end

      // Operation sequencer
      unique case (s_q.st)
         ST_IDLE: begin
         end
         ST_LATCH: begin
            if (erase_sel) begin
               unique case (op)
                  CMD_ERASE8: begin words = WORDS_8; legal = 1'b1; end
                  CMD_ERASE4: begin words = WORDS_4; legal = 1'b1; end
                  CMD_ERASE2: begin words = WORDS_2; legal = 1'b1; end
                  CMD_ERASE_EE: begin is_ee = 1'b1; legal = 1'b1; end
                  default: legal = 1'b0;
               endcase
            end else begin
               legal = (op[CTRL_OP_W-1:3] == CMD_WRITE_TAG);
            end
            // Blocks are aligned from the start of program memory
            s_d.fq.addr = align_addr(s_q.taddr, words);
            s_d.fq.words = words;
            s_d.fq.data = latch_rdata;
            s_d.fq.kind = is_ee ? FOP_ERASE_EE : (erase_sel ? FOP_ERASE : FOP_PROG);
            s_d.then_prog = 1'b0;
            if (!legal || (!is_ee && seg_locked(s_q.taddr, boot_segment_write_lock_i,
                                                general_segment_write_lock_i))) begin
               s_d.ctrl[CTRL_WR_BIT] = 1'b0;
               s_d.ctrl[CTRL_OPERATION_ENABLE_BIT_BIT] = 1'b0;
               s_d.st = ST_IDLE;
               ev[EV_REFUSED] = 1'b1;
            end else if (!erase_sel && !s_q.ctrl[CTRL_SKIP_AUTO_ERASE_BIT_BIT]) begin
               s_d.fq.kind = FOP_ERASE;
               s_d.then_prog = 1'b1;
               s_d.st = ST_ERASE;
            end else begin
               s_d.st = erase_sel ? ST_ERASE : ST_PROG;
            end
         end
         ST_ERASE: begin
            if (flash_done_i) begin
               if (s_q.then_prog) begin
                  s_d.fq.kind = FOP_PROG;
                  s_d.then_prog = 1'b0;
                  s_d.st = ST_PROG;
               end else begin
                  s_d.ctrl[CTRL_WR_BIT] = 1'b0;
                  s_d.ctrl[CTRL_OPERATION_ENABLE_BIT_BIT] = 1'b0;
                  s_d.ctrl[CTRL_ERR_BIT] = 1'b0;
                  s_d.st = ST_IDLE;
                  ev[EV_DONE] = 1'b1;
               end
            end
         end
         ST_PROG: begin
            if (flash_done_i) begin
               s_d.ctrl[CTRL_WR_BIT] = 1'b0;
               s_d.ctrl[CTRL_OPERATION_ENABLE_BIT_BIT] = 1'b0;
               s_d.ctrl[CTRL_ERR_BIT] = 1'b0;
               s_d.st = ST_IDLE;
               ev[EV_DONE] = 1'b1;
            end
         end
      endcase

      // A reset mid-operation abandons it and records the abort
      if (abort_reset_i && s_q.ctrl[CTRL_WR_BIT]) begin
         s_d.ctrl[CTRL_WR_BIT] = 1'b0;
         s_d.ctrl[CTRL_OPERATION_ENABLE_BIT_BIT] = 1'b0;
         s_d.ctrl[CTRL_ERR_BIT] = 1'b1;
         s_d.st = ST_IDLE;
         s_d.then_prog = 1'b0;
         ev = '0;
         ev[EV_ABORT] = 1'b1;
      end

      // Sticky status: an event in the clearing cycle survives
      s_d.stat = (s_q.stat & ~clr) | ev;

      // Serial programming port, clock owned by the programmer
      s_d.sck_s1 = programming_clock_line_i;
      s_d.sck_s2 = s_q.sck_s1;
      s_d.sck_s3 = s_q.sck_s2;
      s_d.sda_s1 = programming_data_line_i;
      s_d.sda_s2 = s_q.sda_s1;
      s_d.rx_valid = 1'b0;
      if (sck_rise && ext_allow && s_q.tx_cnt == '0) begin
         s_d.rx_sh = {s_q.rx_sh[SER_RX_W-2:0], s_q.sda_s2};
         s_d.rx_cnt = s_q.rx_cnt + SER_CNT_W'(1);
         if (s_q.rx_cnt == SER_CNT_W'(SER_RX_W - 1)) begin
            s_d.rx_byte = {s_q.rx_sh[SER_RX_W-2:0], s_q.sda_s2};
            s_d.rx_valid = 1'b1;
            s_d.rx_cnt = '0;
         end
      end
      if (ext_tx_load_i && ext_allow) begin
         s_d.tx_sh = ext_tx_word_i;
         s_d.tx_cnt = SER_CNT_W'(WORD_W);
      end else if (sck_fall && s_q.tx_cnt != '0) begin
         s_d.tx_bit = s_q.tx_sh[WORD_W-1];
         s_d.tx_sh = {s_q.tx_sh[WORD_W-2:0], 1'b0};
         s_d.tx_cnt = s_q.tx_cnt - SER_CNT_W'(1);
      end
      if (!ext_allow) begin
         s_d.tx_cnt = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign prdata_o = s_q.prdata;
   assign irq_o = |(s_q.stat & s_q.ien);
   assign cpu_stall_o = s_q.ctrl[CTRL_WR_BIT];
   assign flash_req_o = (s_q.st == ST_ERASE) | (s_q.st == ST_PROG);
   assign flash_cmd_o = s_q.fq;
   assign programming_data_line_o = s_q.tx_bit;
   assign programming_data_line_oe_o = (s_q.tx_cnt != '0) & ext_allow;
   assign ext_rx_byte_o = s_q.rx_byte;
   assign ext_rx_valid_o = s_q.rx_valid;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   start_needs_key_a: assert property ($rose(s_q.ctrl[CTRL_WR_BIT]) |->
      $past(s_q.key) == KEY_OPEN && $past(pwdata_i[CTRL_OPERATION_ENABLE_BIT_BIT]))
      else $error("start accepted without unlock and enable");

   key_reads_zero_a: assert property (apb_setup && paddr_i == OFF_KEY |=> prdata_o == '0)
      else $error("key register returned data");

   stall_while_busy_a: assert property (s_q.st != ST_IDLE |-> cpu_stall_o && s_q.ctrl[CTRL_WR_BIT])
      else $error("operation running without stall");

   done_clears_a: assert property (s_q.st == ST_PROG && flash_done_i && !abort_reset_i |=>
      !s_q.ctrl[CTRL_WR_BIT] && !s_q.ctrl[CTRL_OPERATION_ENABLE_BIT_BIT] && !s_q.ctrl[CTRL_ERR_BIT] && s_q.stat[EV_DONE])
      else $error("completion did not clear start and enable");

   start_no_sw_clear_a: assert property ($fell(s_q.ctrl[CTRL_WR_BIT]) |->
      $past(flash_done_i) || $past(abort_reset_i) || $past(s_q.st) == ST_LATCH)
      else $error("start bit cleared without hardware cause");

   abort_flag_a: assert property (abort_reset_i && s_q.ctrl[CTRL_WR_BIT] |=>
      s_q.ctrl[CTRL_ERR_BIT] && !s_q.ctrl[CTRL_WR_BIT] && s_q.st == ST_IDLE ##1 !flash_req_o)
      else $error("abort not recorded");

   lock_blocks_a: assert property (s_q.st == ST_LATCH && s_q.ctrl[CTRL_OP_LSB +: CTRL_OP_W] != CMD_ERASE_EE &&
      s_q.taddr < BOOT_SEG_END && !boot_segment_write_lock_i && !abort_reset_i |=>
      s_q.st == ST_IDLE && !flash_req_o && s_q.stat[EV_REFUSED])
      else $error("locked segment was written");

   auto_erase_a: assert property (s_q.st == ST_LATCH && !s_q.ctrl[CTRL_ERASE_BIT] &&
      !s_q.ctrl[CTRL_SKIP_AUTO_ERASE_BIT_BIT] && s_d.st != ST_IDLE && !abort_reset_i |=>
      s_q.st == ST_ERASE && s_q.fq.kind == FOP_ERASE && s_q.then_prog)
      else $error("write skipped its erase");

   ext_guard_a: assert property (!ext_allow |=>
      !programming_data_line_oe_o && s_q.tx_cnt == '0 && !ext_rx_valid_o)
      else $error("protected device drove programming data");

endmodule // pfc_flash_ctrl

// >>> testbench/pfc_flash_model.sv
`timescale 1ns/1ns
module pfc_flash_model import pfc_pkg::*; (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic req_i,
   input wire logic [3:0] lat_i,
   output logic done_o
);
   // ====================
   // Array phase timer
   // ====================
   logic [3:0] cnt_q;
   // One done pulse per phase; a slow lat_i keeps the core stalled longer
   always_ff @(posedge core_clk_i) begin
      if (srst_i || !req_i || done_o) begin
         cnt_q <= 4'h0;
         done_o <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
         done_o <= (cnt_q == lat_i);
      end
   end
endmodule // pfc_flash_model

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top import pfc_pkg::*;;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} pfc_row_t;
   logic clk, srst, psel, pen, pwr, abrt, req, done, stall, irq, oe, txl, bwl, gwl, gss, er;
   logic rdy, se, pck, pdi, pdo, rxv;
   logic [7:0] paddr, rxb;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] boot_segment_protect_field;
   logic [3:0] lat;
   pfc_flash_req_t cmd;
   pfc_row_t rows[12];
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   int rx_hits = 0;
   int n;
   localparam logic [23:0] TXW = 24'hc3a5f0;
   localparam logic [7:0] RXB = 8'h96;

   pfc_flash_ctrl dut_u (.core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(rdy),
      .pslverr_o(er), .irq_o(irq), .cpu_stall_o(stall), .abort_reset_i(abrt), .flash_req_o(req),
      .flash_cmd_o(cmd), .flash_done_i(done), .boot_segment_protect_field_i(boot_segment_protect_field),
      .general_segment_protect_bit_i(gss), .boot_segment_write_lock_i(bwl),
      .general_segment_write_lock_i(gwl), .programming_clock_line_i(pck),
      .programming_data_line_i(pdi), .programming_data_line_o(pdo), .programming_data_line_oe_o(oe),
      .ext_tx_load_i(txl), .ext_tx_word_i(TXW), .ext_rx_byte_o(rxb), .ext_rx_valid_o(rxv));
   pfc_flash_model arr_u (.core_clk_i(clk), .srst_i(srst), .req_i(req), .lat_i(lat), .done_o(done));

   // ====================
   // Helpers
   // ====================
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("mismatch t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   // Holds the request until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Only the bench timeout ends a wait for ready
      do begin
         @(posedge clk);
      end while (rdy !== 1'b1);
      rd = prdata;
      se = er;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask

   task automatic start(input logic [15:0] c);
      apb(1'b1, OFF_KEY, 32'h55);
      apb(1'b1, OFF_KEY, 32'haa);
      apb(1'b1, OFF_CTRL, {16'h0, c});
   endtask

   task automatic op(input logic [15:0] c, input logic [1:0] k, input logic [3:0] w, input logic [15:0] a);
      start(c);
      for (n = 0; n < 20 && req !== 1'b1; n++) @(posedge clk);
      chk(req, 1'b1);
      chk(stall, 1'b1);
      chk(cmd.kind, k);
      if (w != 4'h0) chk({cmd.words, cmd.addr}, {w, a});
   endtask

   task automatic fin(input logic [31:0] cx, input logic [31:0] sx);
      for (n = 0; n < 300 && stall !== 1'b0; n++) @(posedge clk);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, cx);
      apb(1'b0, OFF_STAT, 32'h0);
      chk(rd, sx);
      apb(1'b1, OFF_CLR, 32'h7);
   endtask

   always @(posedge clk) begin
      cyc++;
      if (rxv === 1'b1) rx_hits++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ====================
   // Main sequence
   // ====================
   initial begin
      srst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      abrt = 1'b0; txl = 1'b0; bwl = 1'b1; gwl = 1'b1; boot_segment_protect_field = 3'h7; gss = 1'b1; lat = 4'h2;
      pck = 1'b0; pdi = 1'b0;
      rows = '{'{1'b0, OFF_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_STAT, 32'h0, 32'h0, 1'b0},
         '{1'b1, OFF_IEN, 32'h7, 32'h0, 1'b0}, '{1'b0, OFF_IEN, 32'h0, 32'h7, 1'b0},
         '{1'b1, OFF_KEY, 32'h55, 32'h0, 1'b0}, '{1'b0, OFF_KEY, 32'h0, 32'h0, 1'b0},
         '{1'b1, OFF_CTRL, 32'h3000, 32'h0, 1'b0}, '{1'b0, OFF_CTRL, 32'h0, 32'h3000, 1'b0},
         '{1'b1, OFF_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b1, OFF_STAT, 32'h7, 32'h0, 1'b0},
         '{1'b0, OFF_STAT, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h1c, 32'h0, 32'h0, 1'b1}};
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].x);
         chk(se, rows[i].e);
      end
      apb(1'b0, 8'h1c, 32'h0);
      apb(1'b1, OFF_TADDR, 32'h0423);
      apb(1'b1, OFF_TDATA, 32'h111111);
      apb(1'b1, OFF_TDATA, 32'h5a5a5a);
      chk(req, 1'b0);
      apb(1'b1, OFF_CTRL, 32'hc008);
      repeat (3) @(posedge clk);
      chk(stall, 1'b0);
      // Any access between the key writes breaks the sequence
      apb(1'b1, OFF_KEY, 32'h55);
      apb(1'b0, OFF_STAT, 32'h0);
      apb(1'b1, OFF_KEY, 32'haa);
      apb(1'b1, OFF_CTRL, 32'hc008);
      repeat (3) @(posedge clk);
      chk(stall, 1'b0);
      start(16'h8008);
      repeat (3) @(posedge clk);
      chk(stall, 1'b0);
      op(16'hc008, FOP_ERASE, WORDS_1, 16'h0423);
      for (n = 0; n < 50 && cmd.kind !== FOP_PROG; n++) @(posedge clk);
      chk(cmd.kind, FOP_PROG);
      chk({cmd.addr, 8'h0, cmd.data}, {16'h0423, 8'h0, 24'h5a5a5a});
      for (n = 0; n < 300 && stall !== 1'b0; n++) @(posedge clk);
      chk(irq, 1'b1);
      fin(32'h0008, 32'h1);
      chk(irq, 1'b0);
      op(16'hd008, FOP_PROG, WORDS_1, 16'h0423);
      fin(32'h1008, 32'h1);
      apb(1'b1, OFF_TADDR, 32'h0427);
      op(16'hc05a, FOP_ERASE, WORDS_8, 16'h0420);
      fin(32'h005a, 32'h1);
      op(16'hc059, FOP_ERASE, WORDS_4, 16'h0424);
      fin(32'h0059, 32'h1);
      op(16'hc058, FOP_ERASE, WORDS_2, 16'h0426);
      fin(32'h0058, 32'h1);
      op(16'hc050, FOP_ERASE_EE, 4'h0, 16'h0);
      fin(32'h0050, 32'h1);
      start(16'hc044);
      repeat (3) @(posedge clk);
      chk({req, stall}, 2'b00);
      fin(32'h0044, 32'h4);
      bwl <= 1'b0;
      apb(1'b1, OFF_TADDR, 32'h0010);
      start(16'hc008);
      repeat (3) @(posedge clk);
      chk(req, 1'b0);
      fin(32'h0008, 32'h4);
      bwl <= 1'b1;
      lat <= 4'hc;
      op(16'hc008, FOP_ERASE, WORDS_1, 16'h0010);
      apb(1'b1, OFF_CTRL, 32'h0);
      chk(stall, 1'b1);
      abrt <= 1'b1;
      @(posedge clk);
      abrt <= 1'b0;
      fin(32'h2008, 32'h2);
      boot_segment_protect_field <= 3'h0;
      txl <= 1'b1;
      @(posedge clk);
      txl <= 1'b0;
      repeat (6) @(posedge clk);
      chk(oe, 1'b0);
      boot_segment_protect_field <= 3'h7;
      // Programmer clock idles low between frames; data set a half period ahead
      for (n = 0; n < 8; n++) begin
         pdi <= RXB[7 - n];
         repeat (4) @(posedge clk);
         pck <= 1'b1;
         repeat (4) @(posedge clk);
         pck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      chk(rxb, RXB);
      chk(rx_hits, 1);
      txl <= 1'b1;
      @(posedge clk);
      txl <= 1'b0;
      repeat (6) @(posedge clk);
      chk(oe, 1'b1);
      for (n = 0; n < 24; n++) begin
         pck <= 1'b1;
         repeat (4) @(posedge clk);
         pck <= 1'b0;
         repeat (6) @(posedge clk);
         chk(pdo, TXW[23 - n]);
      end
      chk(oe, 1'b0);
      // Reset in the middle of an operation
      op(16'hc008, FOP_ERASE, WORDS_1, 16'h0010);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({req, stall, oe}, 3'b000);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      close_out();
   end
endmodule // tb_top
